// File: logic/tt_tick_timer.sv
// Eight-bit modulo tick timer with APB register access
`include "tt_defines.svh"

module tt_tick_timer (
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        fixed_freq_clock_i,
    input  wire logic        ext_count_input_i,
    input  wire logic        stop_mode_i,
    input  wire logic        debug_mode_i,
    output logic             irq_o
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    tt_pkg::tt_byte_t count_reg, count_next;
    tt_pkg::tt_byte_t wrap_reg,  wrap_next;
    tt_pkg::tt_src_t  src_reg,   src_next;
    logic [3:0]       dsel_reg,  dsel_next;
    logic             oflag_reg, oflag_next;
    logic             ie_reg,    ie_next;
    logic             halt_reg,  halt_next;
    logic             armed_reg, armed_next;
    logic [31:0]      rdata_reg, rdata_next;

    tt_tick_if link ();

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    logic setup_ph;
    logic acc_wr;
    logic acc_rd;
    logic wr_sc;
    logic wr_clk;
    logic wr_mod;
    logic rd_sc;
    logic clr;
    logic at_wrap;
    logic ovf;

    // True for the four word addresses the block answers
    function automatic logic addr_mapped(input logic [7:0] a);
        return (a == `TT_OFS_SC) || (a == `TT_OFS_CLK) || (a == `TT_OFS_CNT) || (a == `TT_OFS_MOD);
    endfunction : addr_mapped

    // Strobes for the access phase; writes land on the completing edge
    assign setup_ph  = psel_i & ~penable_i;
    assign acc_wr    = psel_i & penable_i & pwrite_i;
    assign acc_rd    = psel_i & penable_i & ~pwrite_i;
    assign wr_sc     = acc_wr && (paddr_i == `TT_OFS_SC);
    assign wr_clk    = acc_wr && (paddr_i == `TT_OFS_CLK);
    assign wr_mod    = acc_wr && (paddr_i == `TT_OFS_MOD);
    assign rd_sc     = acc_rd && (paddr_i == `TT_OFS_SC);
    assign pready_o  = 1'b1;   // Zero wait states
    assign pslverr_o = psel_i & penable_i & ~addr_mapped(paddr_i);
    assign prdata_o  = rdata_reg;

    // Counter restart: clear bit written as one, or any limit write
    assign clr = (wr_sc & pwdata_i[`TT_SC_TRST]) | wr_mod;

    // ----------------------------------------------------------------
    // Prescaler link
    // ----------------------------------------------------------------
    // Wait mode is no input here: the count simply goes on then
    assign link.run             = ~halt_reg & ~stop_mode_i & ~debug_mode_i;
    assign link.clear           = clr;
    assign link.source_select   = src_reg;
    assign link.prescale_select = dsel_reg;

    tt_prescaler u_prescaler (
        .mclk_i             (mclk_i),
        .reset_n_i          (reset_n_i),
        .fixed_freq_clock_i (fixed_freq_clock_i),
        .ext_count_input_i  (ext_count_input_i),
        .link               (link.pre)
    );

    // ----------------------------------------------------------------
    // Counter and flag
    // ----------------------------------------------------------------
    // Wrap point: the limit, or the top of range when the limit is zero
    assign at_wrap = (wrap_reg == `TT_CNT_ZERO) ? (count_reg == `TT_CNT_MAX)
                                                : (count_reg == wrap_reg);
    // A restart in the same cycle wins over the tick, so no overflow then
    assign ovf     = link.tick & at_wrap & ~clr;

    // Read data is captured in setup so it stands during the access phase
    function automatic logic [31:0] read_word(input logic [7:0] a, input logic [7:0] sc,
                                              input logic [7:0] ck, input logic [7:0] cn,
                                              input logic [7:0] md);
        case (a)
            `TT_OFS_SC:  return {24'h0, sc};
            `TT_OFS_CLK: return {24'h0, ck};
            `TT_OFS_CNT: return {24'h0, cn};
            `TT_OFS_MOD: return {24'h0, md};
            default:     return `TT_WORD_ZERO;
        endcase
    endfunction : read_word

    // Next-state logic for all registers
    always_comb begin
        count_next = count_reg;
        wrap_next  = wrap_reg;
        src_next   = src_reg;
        dsel_next  = dsel_reg;
        ie_next    = ie_reg;
        halt_next  = halt_reg;
        armed_next = armed_reg;
        rdata_next = rdata_reg;
        // Count: restart beats tick; halt/stop/debug hold the value
        if (clr) begin
            count_next = `TT_CNT_ZERO;
        end else if (link.tick) begin
            count_next = at_wrap ? `TT_CNT_ZERO : count_reg + 8'h01;
        end
        // Register writes; source or prescale changes leave the count alone
        if (wr_sc) begin
            ie_next   = pwdata_i[`TT_SC_IE];
            halt_next = pwdata_i[`TT_SC_HALT];
        end
        if (wr_clk) begin
            src_next = tt_pkg::tt_src_t'(pwdata_i[`TT_CLK_SRC_HI:`TT_CLK_SRC_LO]);
            dsel_next = pwdata_i[`TT_CLK_DIV_HI:`TT_CLK_DIV_LO];
        end
        if (wr_mod) begin
            wrap_next = pwdata_i[7:0];
        end
        // Flag clear needs a status read while set, then a write of zero; a restart clears it directly
        if (rd_sc && oflag_reg) begin
            armed_next = 1'b1;
        end else if (wr_sc || clr) begin
            armed_next = 1'b0;
        end
        // Overflow sets the flag even in the cycle a zero write clears it
        oflag_next = ovf | (oflag_reg & ~clr & ~(wr_sc & armed_reg & ~pwdata_i[`TT_SC_OFLAG]));
        if (setup_ph && !pwrite_i) begin
            // Clear bit and bits 3..0 always read as zero
            rdata_next = read_word(paddr_i,
                                   {oflag_reg, ie_reg, 1'b0, halt_reg, 4'h0},
                                   {2'b00, src_reg, dsel_reg},
                                   count_reg, wrap_reg);
        end
    end

    // Register stage; a reset out of stop lands here too
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            count_reg <= `TT_CNT_ZERO;
            wrap_reg  <= `TT_CNT_ZERO;
            src_reg   <= tt_pkg::TT_SRC_BUS;
            dsel_reg  <= `TT_DIV_ZERO;
            oflag_reg <= 1'b0;
            ie_reg    <= 1'b0;
            halt_reg  <= `TT_HALT_RST;
            armed_reg <= 1'b0;
            rdata_reg <= `TT_WORD_ZERO;
        end else begin
            count_reg <= count_next;
            wrap_reg  <= wrap_next;
            src_reg   <= src_next;
            dsel_reg  <= dsel_next;
            oflag_reg <= oflag_next;
            ie_reg    <= ie_next;
            halt_reg  <= halt_next;
            armed_reg <= armed_next;
            rdata_reg <= rdata_next;
        end
    end

    // Level request, follows the flag while enabled
    assign irq_o = ie_reg & oflag_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_flag_read;
        rd_sc && oflag_reg;
    endsequence

    sequence s_zero_write;
        wr_sc && !pwdata_i[`TT_SC_OFLAG] && !ovf;
    endsequence

    a_modulo_wrap: assert property (
        link.tick && !clr && wrap_reg != `TT_CNT_ZERO && count_reg == wrap_reg
        |=> count_reg == `TT_CNT_ZERO && oflag_reg && irq_o == ie_reg)
        else $error("Counter did not wrap at the limit");

    a_free_wrap: assert property (
        link.tick && !clr && wrap_reg == `TT_CNT_ZERO && count_reg == `TT_CNT_MAX
        |=> count_reg == `TT_CNT_ZERO && oflag_reg)
        else $error("Free-running count did not wrap at top");

    a_count_step: assert property (
        link.tick && !clr && !at_wrap |=> count_reg == $past(count_reg) + 8'h01)
        else $error("Count did not advance by one");

    a_halt_freeze: assert property (
        halt_reg && !clr |=> count_reg == $past(count_reg))
        else $error("Count moved while halted");

    a_stop_debug_hold: assert property (
        (stop_mode_i || debug_mode_i) && !clr |-> !link.tick ##1 count_reg == $past(count_reg))
        else $error("Count moved in stop or debug");

    a_clear_restart: assert property (
        clr |=> count_reg == `TT_CNT_ZERO && !oflag_reg && !armed_reg)
        else $error("Restart did not zero count and flag");

    a_flag_clear_seq: assert property (
        s_flag_read ##1 (!wr_sc && !clr && !ovf)[*2] ##1 s_zero_write |=> !oflag_reg)
        else $error("Flag did not clear after read then zero write");

    a_flag_no_arm: assert property (
        oflag_reg && !armed_reg && !rd_sc && !clr |=> oflag_reg)
        else $error("Flag cleared without a prior read");

    a_irq_tracks: assert property (
        $rose(oflag_reg) && ie_reg |-> irq_o ##1 (irq_o == (oflag_reg && ie_reg)))
        else $error("Interrupt does not follow enabled flag");

    a_sc_read_zeros: assert property (
        setup_ph && !pwrite_i && paddr_i == `TT_OFS_SC
        |=> prdata_o[`TT_SC_TRST] == 1'b0 && prdata_o[3:0] == 4'h0 && prdata_o[`TT_SC_HALT] == halt_reg)
        else $error("Status read shows wrong fixed bits");

    a_clk_read_zeros: assert property (
        setup_ph && !pwrite_i && paddr_i == `TT_OFS_CLK |=> prdata_o[31:6] == 26'h0)
        else $error("Clock config read shows nonzero fixed bits");

    a_src_keep_count: assert property (
        wr_clk && !link.tick |=> count_reg == $past(count_reg))
        else $error("Clock config write disturbed the count");

    a_count_ro_write: assert property (
        acc_wr && paddr_i == `TT_OFS_CNT && !link.tick |=> count_reg == $past(count_reg))
        else $error("Count register write changed the count");

    a_limit_load: assert property (
        wr_mod |=> wrap_reg == $past(pwdata_i[7:0]))
        else $error("Wrap limit write did not load");

    a_halt_write: assert property (
        wr_sc |=> halt_reg == $past(pwdata_i[`TT_SC_HALT]))
        else $error("Halt bit did not follow the write");

    a_bus_tick_run: assert property (
        !halt_reg && !stop_mode_i && !debug_mode_i && src_reg == tt_pkg::TT_SRC_BUS && dsel_reg == `TT_DIV_ZERO
        |-> link.tick)
        else $error("Running bus source with divide by one did not tick");

    a_stop_no_ovf: assert property (
        stop_mode_i |-> !ovf)
        else $error("Overflow raised during stop");

    a_ovf_sets_flag: assert property (
        ovf |=> oflag_reg)
        else $error("Overflow did not set the flag");

    a_restart_no_ovf: assert property (
        clr |-> !ovf)
        else $error("Overflow raised in a restart cycle");

    a_irq_masked: assert property (
        !ie_reg |-> !irq_o)
        else $error("Interrupt raised while disabled");

    a_count_in_range: assert property (
        wrap_reg != `TT_CNT_ZERO && count_reg <= wrap_reg && !clr |=> count_reg <= wrap_reg)
        else $error("Count passed the wrap limit");

endmodule : tt_tick_timer

// File: logic/tt_defines.svh
// Offsets, field positions, reset values and limits of the tick timer
`ifndef TT_DEFINES_SVH
`define TT_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets on the APB
// ----------------------------------------------------------------
`define TT_OFS_SC       8'h00
`define TT_OFS_CLK      8'h04
`define TT_OFS_CNT      8'h08
`define TT_OFS_MOD      8'h0c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TT_SC_OFLAG     7
`define TT_SC_IE        6
`define TT_SC_TRST      5
`define TT_SC_HALT      4
`define TT_CLK_SRC_HI   5
`define TT_CLK_SRC_LO   4
`define TT_CLK_DIV_HI   3
`define TT_CLK_DIV_LO   0

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define TT_HALT_RST     1'b1
`define TT_CNT_ZERO     8'h00
`define TT_CNT_MAX      8'hff
`define TT_DIV_ZERO     4'h0
`define TT_DIV_MAX      4'h8
`define TT_MASK_ZERO    8'h00
`define TT_MASK_MAX     8'hff
`define TT_WORD_ZERO    32'h0000_0000

`endif

// File: logic/tt_pkg.sv
// Types shared by the tick timer modules
package tt_pkg;

    // ----------------------------------------------------------------
    // Count source encoding as held in the clock configuration register
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        TT_SRC_BUS      = 2'b00,
        TT_SRC_FIXED    = 2'b01,
        TT_SRC_EXT_FALL = 2'b10,
        TT_SRC_EXT_RISE = 2'b11
    } tt_src_t;

    typedef logic [7:0] tt_byte_t;

endpackage : tt_pkg

// File: logic/tt_tick_if.sv
// Link between the register/counter core and the prescaler
interface tt_tick_if;
    tt_pkg::tt_src_t source_select;
    logic [3:0]      prescale_select;
    logic            run;
    logic            clear;
    logic            tick;

    modport core (output source_select, output prescale_select, output run, output clear, input tick);
    modport pre  (input source_select, input prescale_select, input run, input clear, output tick);
endinterface : tt_tick_if

// File: logic/tt_prescaler.sv
// Source selection, input synchronisers and prescaler of the tick timer
`include "tt_defines.svh"

module tt_prescaler (
    input  wire logic mclk_i,
    input  wire logic reset_n_i,
    input  wire logic fixed_freq_clock_i,
    input  wire logic ext_count_input_i,
    tt_tick_if.pre    link
);

    // ----------------------------------------------------------------
    // Synchronisers
    // ----------------------------------------------------------------
    logic [2:0] ext_sync_reg, ext_sync_next;
    logic [2:0] fix_sync_reg, fix_sync_next;
    logic       ext_lvl_reg, ext_lvl_next;
    logic       fix_lvl_reg, fix_lvl_next;
    logic [7:0] pcnt_reg, pcnt_next;
    logic       event_hit;

    // Divide mask: ratio 2**sel minus one, larger codes divide by 256
    function automatic logic [7:0] div_mask(input logic [3:0] sel);
        logic [8:0] one_hot;
        one_hot = 9'h001;
        if (sel >= `TT_DIV_MAX) begin
            return `TT_MASK_MAX;
        end
        one_hot = one_hot << sel;
        return 8'(one_hot - 9'h001);
    endfunction : div_mask

    // Stage one feeds only stage two; a level counts once stages two and three agree
    always_comb begin
        ext_sync_next = {ext_sync_reg[1:0], ext_count_input_i};
        fix_sync_next = {fix_sync_reg[1:0], fixed_freq_clock_i};
        // Input must stay below a quarter of the bus rate or edges merge
        ext_lvl_next  = (ext_sync_reg[1] == ext_sync_reg[2]) ? ext_sync_reg[2] : ext_lvl_reg;
        fix_lvl_next  = (fix_sync_reg[1] == fix_sync_reg[2]) ? fix_sync_reg[2] : fix_lvl_reg;
    end

    // ----------------------------------------------------------------
    // Source edge and divider
    // ----------------------------------------------------------------
    // Choose the edge that feeds the prescaler
    always_comb begin
        case (link.source_select)
            tt_pkg::TT_SRC_BUS:      event_hit = 1'b1;
            tt_pkg::TT_SRC_FIXED:    event_hit = fix_lvl_next & ~fix_lvl_reg;
            tt_pkg::TT_SRC_EXT_FALL: event_hit = ~ext_lvl_next & ext_lvl_reg;
            tt_pkg::TT_SRC_EXT_RISE: event_hit = ext_lvl_next & ~ext_lvl_reg;
            default:                 event_hit = 1'b0;
        endcase
    end

    // Tick when the low bits of the divider are all ones; a halt holds the phase
    assign link.tick = link.run & event_hit & ((pcnt_reg & div_mask(link.prescale_select))
                       == div_mask(link.prescale_select));

    // Divider count advances on each accepted edge, restarts with the counter
    always_comb begin
        pcnt_next = pcnt_reg;
        if (link.clear) begin
            pcnt_next = `TT_MASK_ZERO;
        end else if (link.run && event_hit) begin
            pcnt_next = pcnt_reg + 8'h01;
        end
    end

    // Register stage
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ext_sync_reg <= 3'h0;
            fix_sync_reg <= 3'h0;
            ext_lvl_reg  <= 1'b0;
            fix_lvl_reg  <= 1'b0;
            pcnt_reg     <= `TT_MASK_ZERO;
        end else begin
            ext_sync_reg <= ext_sync_next;
            fix_sync_reg <= fix_sync_next;
            ext_lvl_reg  <= ext_lvl_next;
            fix_lvl_reg  <= fix_lvl_next;
            pcnt_reg     <= pcnt_next;
        end
    end

endmodule : tt_prescaler

// File: dv/tt_ext_src_model.sv
// Partner model of the fixed reference and the external count pin
module tt_ext_src_model (
    input  wire logic mclk_i,
    output logic      fixed_freq_clock_o,
    output logic      ext_count_input_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // Pulse generator
    // ----------------------------------------------------------------
    // Both lines idle low and stand still between bursts
    initial begin
        fixed_freq_clock_o = 1'b0;
        ext_count_input_o  = 1'b0;
    end

    // Eight bus cycles per pulse keeps the rate at one eighth of the bus clock
    task automatic pulses(input logic sel_ext, input int n);
        for (int i = 0; i < n; i++) begin
            repeat (4) @(posedge mclk_i);
            if (sel_ext) begin
                ext_count_input_o <= 1'b1;
            end else begin
                fixed_freq_clock_o <= 1'b1;
            end
            repeat (4) @(posedge mclk_i);
            ext_count_input_o  <= 1'b0;
            fixed_freq_clock_o <= 1'b0;
        end
        // Let the synchronisers drain before the caller reads the count
        repeat (8) @(posedge mclk_i);
    endtask : pulses
endmodule : tt_ext_src_model

// File: dv/modulo_tick_timer_tb_top.sv
// Self-checking testbench of the tick timer
`include "tt_defines.svh"

module modulo_tick_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        mclk        = 1'b0;
    logic        reset_n     = 1'b0;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [7:0]  paddr       = 8'h00;
    logic [31:0] pwdata      = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        fixed_clk;
    logic        ext_in;
    logic        stop_mode   = 1'b0;
    logic        debug_mode  = 1'b0;
    logic        irq;
    int          failures    = 0;
    int          total_checks = 0;
    int          cycles      = 0;

    // 20 MHz bus clock
    always #25 mclk = ~mclk;

    tt_tick_timer u_dut (
        .mclk_i             (mclk),
        .reset_n_i          (reset_n),
        .psel_i             (psel),
        .penable_i          (penable),
        .pwrite_i           (pwrite),
        .paddr_i            (paddr),
        .pwdata_i           (pwdata),
        .prdata_o           (prdata),
        .pready_o           (pready),
        .pslverr_o          (pslverr),
        .fixed_freq_clock_i (fixed_clk),
        .ext_count_input_i  (ext_in),
        .stop_mode_i        (stop_mode),
        .debug_mode_i       (debug_mode),
        .irq_o              (irq)
    );

    tt_ext_src_model u_src (
        .mclk_i             (mclk),
        .fixed_freq_clock_o (fixed_clk),
        .ext_count_input_o  (ext_in)
    );

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; entered just after a rising edge, waits for pready without assuming latency
    // An idle edge follows the release so back-to-back calls never drive a strobe twice in one step
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) begin
            @(posedge mclk);
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(a, 1'b1, d, q, e);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(a, 1'b0, 32'h0000_0000, q, e);
        check(q, exp);
    endtask : rd_chk

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        apb(a, 1'b0, 32'h0000_0000, q, e);
    endtask : rd

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rd_chk(`TT_OFS_SC, 32'h0000_0010);
        rd_chk(`TT_OFS_CLK, 32'h0000_0000);
        rd_chk(`TT_OFS_CNT, 32'h0000_0000);
        rd_chk(`TT_OFS_MOD, 32'h0000_0000);
        check({31'h0, irq}, 32'h0);
    endtask : t_reset

    task automatic t_regs();
        logic [31:0] q;
        logic        e;
        wr(`TT_OFS_CLK, 32'hffff_ffff);
        rd_chk(`TT_OFS_CLK, 32'h0000_003f);
        wr(`TT_OFS_SC, 32'h0000_0070);
        rd_chk(`TT_OFS_SC, 32'h0000_0050);
        wr(`TT_OFS_SC, 32'h0000_0010);
        wr(`TT_OFS_CNT, 32'h0000_0055);
        rd_chk(`TT_OFS_CNT, 32'h0000_0000);
        wr(`TT_OFS_MOD, 32'h0000_00a5);
        rd_chk(`TT_OFS_MOD, 32'h0000_00a5);
        // Unmapped word answers with an error and reads zero
        apb(8'h10, 1'b0, 32'h0000_0000, q, e);
        check({31'h0, e}, 32'h1);
        check(q, 32'h0);
        wr(`TT_OFS_CLK, 32'h0000_0000);
    endtask : t_regs

    // Edges from release to the first visible interrupt; the loop sees each update one edge late
    task automatic t_wrap(input logic [7:0] lim);
        int n;
        n = 0;
        wr(`TT_OFS_SC, 32'h0000_0010);
        wr(`TT_OFS_MOD, {24'h0, lim});
        wr(`TT_OFS_SC, 32'h0000_0040);
        while (irq !== 1'b1 && n < 400) begin
            @(posedge mclk);
            n++;
        end
        check(n, (lim == 8'h00) ? 32'd256 : 32'(lim) + 32'd1);
        wr(`TT_OFS_SC, 32'h0000_0050);
        rd_chk(`TT_OFS_SC, 32'h0000_00d0);
        check({31'h0, irq}, 32'h1);
        wr(`TT_OFS_SC, 32'h0000_0050);
        check({31'h0, irq}, 32'h0);
        rd_chk(`TT_OFS_SC, 32'h0000_0050);
    endtask : t_wrap

    // Flag without enable, halt freeze, then both restart paths
    task automatic t_clear();
        logic [31:0] a;
        for (int k = 0; k < 2; k++) begin
            wr(`TT_OFS_MOD, 32'h0000_0001);
            wr(`TT_OFS_SC, 32'h0000_0000);
            repeat (10) @(posedge mclk);
            wr(`TT_OFS_SC, 32'h0000_0010);
            rd_chk(`TT_OFS_SC, 32'h0000_0090);
            check({31'h0, irq}, 32'h0);
            rd(`TT_OFS_CNT, a);
            repeat (20) @(posedge mclk);
            rd_chk(`TT_OFS_CNT, a);
            if (k == 0) begin
                wr(`TT_OFS_SC, 32'h0000_0030);
            end else begin
                wr(`TT_OFS_MOD, 32'h0000_0001);
            end
            rd_chk(`TT_OFS_CNT, 32'h0000_0000);
            rd_chk(`TT_OFS_SC, 32'h0000_0010);
        end
    endtask : t_clear

    // Ten divided ticks per code; pipeline slack allows one tick less
    task automatic t_prescale();
        logic [31:0] c;
        int          d;
        for (int code = 0; code < 10; code++) begin
            d = (code >= 8) ? 256 : (1 << code);
            wr(`TT_OFS_SC, 32'h0000_0010);
            wr(`TT_OFS_MOD, 32'h0000_0000);
            wr(`TT_OFS_CLK, 32'(code));
            wr(`TT_OFS_SC, 32'h0000_0000);
            repeat (10 * d - 3) @(posedge mclk);
            wr(`TT_OFS_SC, 32'h0000_0010);
            rd(`TT_OFS_CNT, c);
            check({31'h0, (c === 32'd9 || c === 32'd10)}, 32'h1);
        end
    endtask : t_prescale

    // Source changes keep the count running on
    task automatic t_sources();
        wr(`TT_OFS_MOD, 32'h0000_0000);
        wr(`TT_OFS_CLK, 32'h0000_0010);
        wr(`TT_OFS_SC, 32'h0000_0000);
        u_src.pulses(1'b0, 5);
        rd_chk(`TT_OFS_CNT, 32'h0000_0005);
        wr(`TT_OFS_CLK, 32'h0000_0020);
        u_src.pulses(1'b1, 5);
        rd_chk(`TT_OFS_CNT, 32'h0000_000a);
        wr(`TT_OFS_CLK, 32'h0000_0030);
        u_src.pulses(1'b1, 5);
        rd_chk(`TT_OFS_CNT, 32'h0000_000f);
        wr(`TT_OFS_CLK, 32'h0000_0000);
    endtask : t_sources

    // Stop and debug freeze the count, which resumes afterwards
    task automatic t_modes();
        logic [31:0] b;
        logic [31:0] c;
        wr(`TT_OFS_MOD, 32'h0000_0000);
        wr(`TT_OFS_SC, 32'h0000_0000);
        for (int m = 0; m < 2; m++) begin
            stop_mode  <= (m == 0);
            debug_mode <= (m == 1);
            repeat (2) @(posedge mclk);
            rd(`TT_OFS_CNT, b);
            repeat (30) @(posedge mclk);
            rd_chk(`TT_OFS_CNT, b);
            stop_mode  <= 1'b0;
            debug_mode <= 1'b0;
            repeat (5) @(posedge mclk);
            rd(`TT_OFS_CNT, c);
            check({31'h0, (c !== b)}, 32'h1);
        end
    endtask : t_modes

    // ----------------------------------------------------------------
    // Main sequence and hang guard
    // ----------------------------------------------------------------
    // Ceiling well above the roughly eight and a half thousand cycles the run needs
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            failures++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        t_reset();
        t_regs();
        t_wrap(8'h03);
        t_wrap(8'h00);
        t_clear();
        t_prescale();
        t_sources();
        t_modes();
        tally_and_finish();
    end
endmodule : modulo_tick_timer_tb_top
